// [touch_power_mode_control.sv]
// Scan pacing, power modes, host notification, hopping and baseline upkeep.
// Assumes scan engine and I2C decode on i_sys_clk; INT pin has a board pull.
//
// What this block does
// RULE1: Normal mode repeats a scan every 7 to 10 ms, as configured.
// RULE2: Normal mode with no touch falls to idle scan after 0-15 s timeout.
// RULE3: Idle scan mode scans every 40 ms regardless of normal period setting.
// RULE4: Any touch seen in idle scan mode returns the block to normal mode.
// RULE5: Host pulls INT low, then sends the sleep command.
// RULE6: Host holds INT high 2-5 ms; the block then wakes to normal mode.
// RULE7: INT is pulsed only when a touch event makes coordinates ready.
// RULE8: Trigger setting 0 signals with a rising edge, 1 with a falling edge.
// RULE9: Noise overlapping the drive spectrum moves the drive to another frequency.
// RULE10: Baseline is set from current conditions within 200 ms after reset.
// RULE11: Baseline follows slow drift by comparing history with current samples.
// RULE12: Sleep suspends scanning and interrupts until a valid wake pulse.
`timescale 1ns/1ps
module touch_power_mode_control #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES_DFLT
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_int_in,
  input wire logic i_sleep_cmd,
  input wire logic i_int_falling,
  input wire logic [3:0] i_scan_period_ms,
  input wire logic [3:0] i_idle_timeout_s,
  input wire logic i_scan_done,
  input wire logic i_touch_present,
  input wire logic i_noise_overlap,
  input wire logic [7:0] i_sample,
  output touch_pkg::mode_t o_mode,
  output logic o_scan_start,
  output logic o_int_out,
  output logic o_int_oe_n,
  output logic [2:0] o_freq_sel,
  output logic o_calib_done,
  output logic o_baseline_update,
  output logic o_baseline_recal,
  output logic [7:0] o_baseline_ref
);
  import touch_pkg::*;

  localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);

  state_t st_ff;
  state_t nxt_st;
  logic active;
  logic touch_evt;
  logic clean_scan;
  logic [5:0] period;

  // ==========================================
  // Helpers
  function automatic logic [5:0] scan_period(input logic [3:0] cfg);
    logic [5:0] p;
    p = {2'b00, cfg};
    if (p < `SCAN_MIN_MS) begin
      p = `SCAN_MIN_MS;
    end else if (p > `SCAN_MAX_MS) begin
      p = `SCAN_MAX_MS;
    end
    return p;
  endfunction

  function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? (a - b) : (b - a);
  endfunction

  // ==========================================
  // Next state
  always_comb begin
    nxt_st = st_ff;
    // Only bit 1 is read; bit 0 is the metastability catcher
    nxt_st.int_sync = {st_ff.int_sync[0], i_int_in};
    nxt_st.tick = 1'b0;
    nxt_st.scan_start = 1'b0;
    nxt_st.recal = 1'b0;
    nxt_st.base_upd = 1'b0;
    active = (st_ff.mode != MODE_SLEEP);
    touch_evt = active && i_scan_done && i_touch_present;
    clean_scan = active && i_scan_done && !i_touch_present;

    // 1 ms tick keeps the long counters narrow
    if (st_ff.tick_cnt == TICK_LAST) begin
      nxt_st.tick_cnt = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.tick_cnt = st_ff.tick_cnt + 18'h00001;
    end

    if (!st_ff.calib_done && st_ff.tick) begin
      if (st_ff.calib_ms == `CALIB_MS - 8'h01) begin
        nxt_st.calib_done = 1'b1; // [RULE10]
      end else begin
        nxt_st.calib_ms = st_ff.calib_ms + 8'h01;
      end
    end

    // Scan pacing
    period = (st_ff.mode == MODE_IDLE) ? `IDLE_SCAN_MS : scan_period(i_scan_period_ms); // [RULE1] [RULE3]
    if (active && st_ff.tick) begin // [RULE12]
      if (st_ff.scan_ms >= period - 6'h01) begin
        nxt_st.scan_ms = '0;
        nxt_st.scan_start = 1'b1;
      end else begin
        nxt_st.scan_ms = st_ff.scan_ms + 6'h01;
      end
    end

    if (active && i_scan_done && i_noise_overlap) begin
      nxt_st.freq_sel = st_ff.freq_sel + 3'h1; // [RULE9]
    end

    // Baseline: untouched scans only, so a finger never becomes the reference
    if (clean_scan) begin
      if (!st_ff.calib_done) begin
        nxt_st.hist = i_sample; // [RULE10]
        nxt_st.base_upd = 1'b1;
      end else begin
        nxt_st.hist = (i_sample > st_ff.hist) ?
          st_ff.hist + ((i_sample - st_ff.hist) >> `HIST_SHIFT) :
          st_ff.hist - ((st_ff.hist - i_sample) >> `HIST_SHIFT); // [RULE11]
        nxt_st.recal = (abs_diff(i_sample, st_ff.hist) > `DRIFT_THRESH); // [RULE11]
      end
    end

    // Notification pulse
    if (st_ff.int_cnt != 5'h00) begin
      nxt_st.int_cnt = st_ff.int_cnt - 5'h01;
    end
    if (touch_evt) begin
      nxt_st.int_cnt = `INT_PULSE_CYCLES; // [RULE7]
    end

    // Mode control
    if (active && i_sleep_cmd && !st_ff.int_sync[1]) begin // [RULE5]
      nxt_st.mode = MODE_SLEEP;
      nxt_st.wake_ticks = '0;
      nxt_st.scan_ms = '0;
      // A scan falling due on the entry edge is dropped, not started late
      nxt_st.scan_start = 1'b0; // [RULE12]
      nxt_st.int_cnt = '0; // [RULE12]
    end else begin
      unique case (st_ff.mode)
        MODE_NORMAL: begin
          if (touch_evt) begin
            nxt_st.idle_ms = '0;
          end else if (st_ff.tick) begin
            if (st_ff.idle_ms >= 14'(i_idle_timeout_s) * `MS_PER_S) begin // [RULE2]
              nxt_st.mode = MODE_IDLE;
              nxt_st.idle_ms = '0;
              nxt_st.scan_ms = '0;
            end else begin
              nxt_st.idle_ms = st_ff.idle_ms + 14'h0001;
            end
          end
        end
        MODE_IDLE: begin
          if (touch_evt) begin
            nxt_st.mode = MODE_NORMAL; // [RULE4]
            nxt_st.scan_ms = '0;
          end
        end
        MODE_SLEEP: begin
          // Three ticks while high guarantee at least 2 ms held
          if (!st_ff.int_sync[1]) begin
            nxt_st.wake_ticks = '0;
          end else if (st_ff.tick) begin
            if (st_ff.wake_ticks == `WAKE_TICKS - 3'h1) begin
              nxt_st.mode = MODE_NORMAL; // [RULE6]
              nxt_st.wake_ticks = '0;
              nxt_st.idle_ms = '0;
            end else begin
              nxt_st.wake_ticks = st_ff.wake_ticks + 3'h1;
            end
          end
        end
      endcase
    end

    // Pin is driven only during a pulse; the board pull holds the idle level
    nxt_st.int_oe_n = (nxt_st.int_cnt == 5'h00);
    nxt_st.int_out = !i_int_falling; // [RULE8]
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      st_ff <= STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_mode = st_ff.mode;
  assign o_scan_start = st_ff.scan_start;
  assign o_int_out = st_ff.int_out;
  assign o_int_oe_n = st_ff.int_oe_n;
  assign o_freq_sel = st_ff.freq_sel;
  assign o_calib_done = st_ff.calib_done;
  assign o_baseline_update = st_ff.base_upd;
  assign o_baseline_recal = st_ff.recal;
  assign o_baseline_ref = st_ff.hist;

  // ==========================================
  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  sleep_no_scan_a: assert property (st_ff.mode == MODE_SLEEP |-> !o_scan_start && o_int_oe_n) // [RULE12]
    else $error("scan or interrupt while asleep");
  idle_return_a: assert property ( // [RULE4]
    st_ff.mode == MODE_IDLE && i_scan_done && i_touch_present && !i_sleep_cmd |=> st_ff.mode == MODE_NORMAL)
    else $error("touch in idle scan did not return to normal");
  int_pulse_a: assert property (touch_evt |=> !o_int_oe_n [*8] ##1 o_int_out == !$past(i_int_falling)) // [RULE7]
    else $error("touch event not signalled on INT");
  int_edge_a: assert property (!o_int_oe_n |-> o_int_out == !$past(i_int_falling)) // [RULE8]
    else $error("INT pulse has wrong polarity");
  int_cause_a: assert property ($fell(o_int_oe_n) |-> $past(touch_evt)) // [RULE7]
    else $error("INT driven without touch event");
  idle_scan_a: assert property ( // [RULE3]
    o_scan_start && $past(st_ff.mode) == MODE_IDLE && st_ff.mode == MODE_IDLE
    |-> $past(st_ff.scan_ms) == 6'h27)
    else $error("idle scan period not 40 ms");
  norm_scan_a: assert property ( // [RULE1]
    o_scan_start && $past(st_ff.mode) == MODE_NORMAL
    |-> $past(st_ff.scan_ms) >= 6'h06 && $past(st_ff.scan_ms) <= 6'h09)
    else $error("normal scan period outside 7-10 ms");
  idle_entry_a: assert property ( // [RULE2]
    st_ff.mode == MODE_NORMAL && st_ff.tick && !touch_evt && !i_sleep_cmd
    && st_ff.idle_ms >= 14'(i_idle_timeout_s) * 14'h03E8 |=> st_ff.mode == MODE_IDLE)
    else $error("idle timeout did not enter idle scan");
  wake_a: assert property ( // [RULE6]
    st_ff.mode == MODE_SLEEP && st_ff.tick && st_ff.int_sync[1] && st_ff.wake_ticks == 3'h2
    |=> st_ff.mode == MODE_NORMAL)
    else $error("valid wake pulse ignored");
  hop_a: assert property ( // [RULE9]
    active && i_scan_done && i_noise_overlap |=> o_freq_sel == $past(o_freq_sel) + 3'h1)
    else $error("noise did not move drive frequency");
  calib_a: assert property (!o_calib_done |-> st_ff.calib_ms < 8'hC8) // [RULE10]
    else $error("initial calibration overran 200 ms");
  drift_a: assert property ( // [RULE11]
    clean_scan && o_calib_done && abs_diff(i_sample, st_ff.hist) > 8'h08 |=> o_baseline_recal)
    else $error("drift not recalibrated");

  idle_seen_c: cover property (st_ff.mode == MODE_NORMAL ##1 st_ff.mode == MODE_IDLE);
  sleep_seen_c: cover property (st_ff.mode != MODE_SLEEP ##1 st_ff.mode == MODE_SLEEP);
  wake_seen_c: cover property (st_ff.mode == MODE_SLEEP ##1 st_ff.mode == MODE_NORMAL);
  int_seen_c: cover property ($fell(o_int_oe_n));
endmodule

// [touch_params.svh]
// Timing counts and drift thresholds of the touch power-mode controller.
// Assumes a 200 MHz system clock; included by the package only.
`ifndef TOUCH_PARAMS_SVH
`define TOUCH_PARAMS_SVH
// ==========================================
// Clock and base tick
`define SYS_CLK_PERIOD_NS 5
`define TICK_TIME_NS 1000000
`define TICK_CYCLES_DFLT (`TICK_TIME_NS / `SYS_CLK_PERIOD_NS)
// ==========================================
// Scan timing in ms
`define SCAN_MIN_MS 6'h07
`define SCAN_MAX_MS 6'h0A
`define IDLE_SCAN_MS 6'h28
`define MS_PER_S 14'h03E8
// ==========================================
// Wake pulse and calibration
`define WAKE_MIN_MS 3'h2
`define WAKE_TICKS (`WAKE_MIN_MS + 3'h1)
`define CALIB_MS 8'hC8
// ==========================================
// Host notification pulse
`define INT_PULSE_NS 100
`define INT_PULSE_CYCLES 5'(`INT_PULSE_NS / `SYS_CLK_PERIOD_NS)
// ==========================================
// Drift tracking
`define DRIFT_THRESH 8'h08
`define HIST_SHIFT 2
`endif

// [touch_pkg.sv]
// Types of the touch power-mode controller.
// Assumes touch_params.svh is on the include path.
`include "touch_params.svh"
package touch_pkg;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_IDLE, MODE_SLEEP} mode_t;
  typedef struct packed {
    mode_t mode;
    logic [1:0] int_sync;
    logic [17:0] tick_cnt;
    logic tick;
    logic [5:0] scan_ms;
    logic [13:0] idle_ms;
    logic [2:0] wake_ticks;
    logic [7:0] calib_ms;
    logic calib_done;
    logic [4:0] int_cnt;
    logic int_out;
    logic int_oe_n;
    logic scan_start;
    logic [2:0] freq_sel;
    logic [7:0] hist;
    logic recal;
    logic base_upd;
  } state_t;
  localparam state_t STATE_RST = '{mode: MODE_NORMAL, int_oe_n: 1'b1, default: '0};
endpackage

// [host_model.sv]
// Host model: drives INT beside the device, issues sleep commands.
// Assumes the board pull on INT follows the trigger mode.
`timescale 1ns/1ps
module host_model (
  input wire logic i_sys_clk,
  input wire logic i_int_falling,
  input wire logic i_int_out,
  input wire logic i_int_oe_n,
  output logic o_int_wire,
  output logic o_sleep_cmd
);
  logic oe = 1'b0;
  logic val = 1'b0;
  initial o_sleep_cmd = 1'b0;
  // ====
  // Wire level
  // Device drive wins, then host drive, then the pull
  assign o_int_wire = !i_int_oe_n ? i_int_out : (oe ? val : i_int_falling);
  // ====
  // Host actions
  // Drive stays on afterwards so a sleeping device never sees the pull
  task automatic hold(input logic v, input int n);
    oe = 1'b1;
    val = v;
    repeat (n) @(negedge i_sys_clk);
  endtask
  // low=0 skips the pull-down to see the command dropped
  task automatic sleep_req(input logic low);
    oe = low;
    val = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    o_sleep_cmd = 1'b1;
    @(negedge i_sys_clk);
    o_sleep_cmd = 1'b0;
  endtask
endmodule

// [testbench.sv]
// Testbench: controller against the host model, self-checking.
// Assumes a 20-cycle tick stands for one millisecond.
`timescale 1ns/1ps
module testbench;
  import touch_pkg::*;
  localparam int TK = 20;
  localparam int PV[5] = '{7, 8, 10, 3, 15};
  localparam int PE[5] = '{7, 8, 10, 7, 10};
  logic wire_l, sleep, start, out, oe_n, cal, upd, recal;
  // Clock starts low so no false falling edge wakes the watcher at time zero
  logic clk = 1'b0, rstn = 1'b0, falling = 1'b0, done = 1'b0, touch = 1'b0, noise = 1'b0, oe_d = 1'b1;
  logic [3:0] period = 4'h7, tmo = 4'hF;
  logic [7:0] sample = 8'h00, base, ref_v;
  logic [2:0] fs, fs_d = 3'h0, fs_exp = 3'h0;
  mode_t mode;
  logic int_q[$];
  logic [2:0] fs_q[$];
  int bad_count, n_tests, low_n, n, d;
  // ====
  // Clock, device and host
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  touch_power_mode_control #(.TICK_CYCLES(TK)) u_dut (.i_sys_clk(clk), .i_rstn(rstn), .i_int_in(wire_l),
    .i_sleep_cmd(sleep), .i_int_falling(falling), .i_scan_period_ms(period), .i_idle_timeout_s(tmo),
    .i_scan_done(done), .i_touch_present(touch), .i_noise_overlap(noise), .i_sample(sample), .o_mode(mode),
    .o_scan_start(start), .o_int_out(out), .o_int_oe_n(oe_n), .o_freq_sel(fs), .o_calib_done(cal),
    .o_baseline_update(upd), .o_baseline_recal(recal), .o_baseline_ref(ref_v));
  host_model u_host (.i_sys_clk(clk), .i_int_falling(falling), .i_int_out(out), .i_int_oe_n(oe_n),
    .o_int_wire(wire_l), .o_sleep_cmd(sleep));
  // ====
  // Helpers
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %0h want %0h", $time, got, exp);
    end
  endtask
  // Cycles to the next scan start or idle entry; a hang ends the run
  task automatic wait_ev(input bit idle, output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while ((idle ? mode !== MODE_IDLE : start !== 1'b1) && c < 21000);
    if (c == 21000) begin
      bad_count++;
      results();
    end
  endtask
  // One scan result; notes the INT pulse and hop it must cause
  task automatic scan(input logic t, input logic nz, input logic [7:0] s);
    done = 1'b1;
    touch = t;
    noise = nz;
    sample = s;
    if (mode != MODE_SLEEP && t) int_q.push_back(!falling);
    if (mode != MODE_SLEEP && nz) begin
      fs_exp = fs_exp + 3'h1;
      fs_q.push_back(fs_exp);
    end
    @(negedge clk);
    done = 1'b0;
  endtask
  // ====
  // Watcher: each INT pulse and hop must match the oldest note
  always @(negedge clk) begin
    if (oe_d && !oe_n) begin
      if (int_q.size() == 0) chk(1, 0);
      else chk(out, int_q.pop_front());
    end
    if (!oe_n) low_n++;
    else if (low_n != 0) begin
      chk(low_n, 20);
      low_n = 0;
    end
    if (fs !== fs_d) chk(fs, fs_q.size() != 0 ? fs_q.pop_front() : fs_d);
    oe_d = oe_n;
    fs_d = fs;
  end
  // ====
  // Main sequence
  initial begin
    void'($urandom(32'hD05D7EA6));
    repeat (5) @(negedge clk);
    chk({mode, oe_n, start, out, fs, cal, upd, recal, ref_v}, 19'h10000);
    rstn = 1'b1;
    repeat (10) @(negedge clk);
    base = 8'($urandom % 128);
    scan(1'b0, 1'b0, base);
    chk({cal, upd, ref_v}, {2'b01, base});
    @(negedge clk);
    foreach (PV[i]) begin
      period = 4'(PV[i]);
      wait_ev(0, n);
      wait_ev(0, n);
      chk(n, TK * PE[i]);
    end
    for (int i = 0; i < 10; i++) begin
      falling = 1'(i % 2);
      repeat (2) @(negedge clk);
      scan(1'b1, 1'(i < 9), 8'($urandom));
      repeat (25) @(negedge clk);
    end
    repeat (4000) @(negedge clk);
    chk(cal, 1'b1);
    for (int i = 0; i < 2; i++) begin
      d = i ? 8 : 9 + $urandom % 100;
      scan(1'b0, 1'b0, base + 8'(d));
      base = base + 8'(d / 4);
      chk({upd, recal, ref_v}, {1'b0, d > 8, base});
      @(negedge clk);
    end
    scan(1'b1, 1'b0, 8'h00);
    tmo = 4'h1;
    wait_ev(1, n);
    tmo = 4'hF;
    chk(n >= 1000 * TK - TK && n <= 1000 * TK + TK, 1);
    wait_ev(0, n);
    wait_ev(0, n);
    chk(n, 40 * TK);
    scan(1'b1, 1'b0, 8'h00);
    chk(mode, MODE_NORMAL);
    repeat (30) @(negedge clk);
    u_host.sleep_req(1'b0);
    chk(mode, MODE_NORMAL);
    u_host.sleep_req(1'b1);
    chk(mode, MODE_SLEEP);
    scan(1'b1, 1'b1, 8'h00);
    n = 0;
    repeat (500) begin
      @(negedge clk);
      n += start;
    end
    chk(n, 0);
    u_host.hold(1'b1, 15);
    u_host.hold(1'b0, 40);
    chk(mode, MODE_SLEEP);
    u_host.hold(1'b1, 4 * TK);
    chk(mode, MODE_NORMAL);
    chk(int_q.size() + fs_q.size(), 0);
    results();
  end
endmodule
